// file: ccs_ctrl.v
// Control and status-change register bank of a removable card socket.
// Assumes a synchronous indexed register port and card pins sampled on clock.
//
// How it works
// [RULE_01] Drive bit low tri-states socket outputs and holds both buffer enables high.
// [RULE_02] Software sets drive enable only after setting card power enable.
// [RULE_03] Power enable low keeps supply at 0 V; high applies selected voltage.
// [RULE_04] With power enabled, supply follows card insertion and removal.
// [RULE_05] Software enables power only when voltage select holds 0x01.
// [RULE_06] Reserved bit 1 reads 0, bit 5 reads 1, others read 0.
// [RULE_07] Software keeps ring-indicate select at 0; ignored for memory cards.
// [RULE_08] Card reset output stays active until software writes reset bit 1.
// [RULE_09] Card type bit 0 means memory card, 1 means I/O card.
// [RULE_10] Steering field routes busy interrupt to none or IRQ 3, 4, 5, 7, 9 to 12, 14 or 15.
// [RULE_11] Detect flag sets when either card-detect input changes.
// [RULE_12] Ready flag sets on busy rising edge for memory cards only; the code sets it on the busy_n rising edge, when busy ends.
// [RULE_13] Battery flag sets on battery dead, or I/O status-change low with select 0.
// [RULE_14] Second battery-voltage input is tied low internally.
// [RULE_15] Flags request interrupt only when enabled; cleared enable forces flag 0.
// [RULE_16] In write-back mode, writing 1 to a flag clears it.
// [RULE_17] In write-back mode the request holds until every flag is 0.
// [RULE_18] Otherwise reading the status register clears flags and the request.
// [RULE_19] Detect, ready and battery enables gate their flag's interrupt request.
// [RULE_20] Steered IRQs are gated by masks and ORed into one socket interrupt.
// [RULE_21] Card inputs pass a two-flop synchroniser before edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defs.vh"

module ccs_ctrl (
  input wire clock,
  input wire rst_n,
  input wire [7:0] reg_index,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire [7:0] voltage_select_reg,
  input wire detect_change_enable,
  input wire ready_change_enable,
  input wire battery_change_enable,
  input wire [3:0] status_irq_steering,
  input wire explicit_writeback_mode,
  input wire [15:0] irq_line_mask,
  input wire card_access,
  input wire card_detect_a_n,
  input wire card_detect_b_n,
  input wire card_busy_n,
  input wire card_status_change_n,
  output reg socket_out_en,
  output reg data_buffer_enable_n,
  output reg address_buffer_enable_n,
  output reg card_power_on,
  output reg [7:0] card_supply_select,
  output reg card_reset_out,
  output reg card_is_io,
  output reg socket_irq
);

  // ----------------------------------------------------------------------
  // Steering decode
  // ----------------------------------------------------------------------
  // Reserved codes decode to no line, so a bad setting cannot raise a stray IRQ.
  // Each code names its line outright, so no branch indexes by a variable.
  function [15:0] steer;
    input [3:0] code;
    input req;
    begin
      steer = 16'h0000;
      case (code) // [RULE_10]
        4'h3: begin
          steer[3] = req;
        end
        4'h4: begin
          steer[4] = req;
        end
        4'h5: begin
          steer[5] = req;
        end
        4'h7: begin
          steer[7] = req;
        end
        4'h9: begin
          steer[9] = req;
        end
        4'ha: begin
          steer[10] = req;
        end
        4'hb: begin
          steer[11] = req;
        end
        4'hc: begin
          steer[12] = req;
        end
        4'he: begin
          steer[14] = req;
        end
        4'hf: begin
          steer[15] = req;
        end
        default: begin
          steer = 16'h0000;
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  reg drive_enable;
  reg socket_power_enable;
  reg ring_indicate_select;
  reg card_reset_control;
  reg card_type_select;
  reg [3:0] irq_steering_field;

  wire wr_power = reg_write && (reg_index == `CCS_IDX_POWER_DRIVE);
  wire wr_general = reg_write && (reg_index == `CCS_IDX_INT_GENERAL);
  wire wr_status = reg_write && (reg_index == `CCS_IDX_STATUS_CHG);
  wire rd_status = reg_read && (reg_index == `CCS_IDX_STATUS_CHG);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_enable <= 1'b0;
      socket_power_enable <= 1'b0;
      ring_indicate_select <= 1'b0;
      card_reset_control <= 1'b0;
      card_type_select <= 1'b0;
      irq_steering_field <= `CCS_IRQSEL_RESET;
    end else begin
      if (wr_power) begin
        drive_enable <= reg_wdata[`CCS_PD_OE_BIT];
        socket_power_enable <= reg_wdata[`CCS_PD_PWR_BIT];
      end
      if (wr_general) begin
        ring_indicate_select <= reg_wdata[`CCS_IG_RI_BIT];
        card_reset_control <= reg_wdata[`CCS_IG_RST_BIT];
        card_type_select <= reg_wdata[`CCS_IG_TYPE_BIT];
        irq_steering_field <= reg_wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Stage one is read only by stage two; stage three holds the last value for edges.
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  reg [3:0] sync_c;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 4'hf;
      sync_b <= 4'hf;
      sync_c <= 4'hf;
    end else begin
      sync_a <= {card_status_change_n, card_busy_n, card_detect_b_n, card_detect_a_n}; // [RULE_21]
      sync_b <= sync_a; // [RULE_21]
      sync_c <= sync_b;
    end
  end

  wire detect_a_n = sync_b[0];
  wire detect_b_n = sync_b[1];
  wire busy_n = sync_b[2];
  wire status_n = sync_b[3];
  wire card_present = !detect_a_n && !detect_b_n;
  // Cards provide no second battery-voltage signal.
  wire battery_voltage2_in = 1'b0; // [RULE_14]

  // ----------------------------------------------------------------------
  // Status-change flags
  // ----------------------------------------------------------------------
  wire detect_event = (sync_b[1:0] != sync_c[1:0]); // [RULE_11]
  wire ready_event = !card_type_select && busy_n && !sync_c[2]; // [RULE_12]
  // Battery dead is both battery-voltage lines low; the second is tied low.
  wire battery_now = card_type_select ? (!ring_indicate_select && !status_n) :
                     (!status_n && !battery_voltage2_in); // [RULE_13]
  wire battery_was = card_type_select ? (!ring_indicate_select && !sync_c[3]) :
                     (!sync_c[3] && !battery_voltage2_in);
  // The flag sets on entry to the condition, so a read-clear is not undone at once.
  wire battery_event = battery_now && !battery_was; // [RULE_13]

  reg detect_change_flag;
  reg ready_change_flag;
  reg battery_status_flag;
  reg [2:0] next_flags;
  reg [2:0] clear_flags;
  reg [2:0] set_flags;
  reg [2:0] enables;

  always @* begin
    enables = {detect_change_enable, ready_change_enable, battery_change_enable};
    set_flags = {detect_event, ready_event, battery_event};
    clear_flags = 3'b000;
    if (explicit_writeback_mode && wr_status) begin
      clear_flags = {reg_wdata[`CCS_SC_DETECT_BIT], reg_wdata[`CCS_SC_READY_BIT],
                     reg_wdata[`CCS_SC_BATTERY_BIT]}; // [RULE_16]
    end
    if (!explicit_writeback_mode && rd_status) begin
      clear_flags = 3'b111; // [RULE_18]
    end
    // A new event in the clearing cycle survives the clear.
    next_flags = ({detect_change_flag, ready_change_flag, battery_status_flag} &
                  ~clear_flags) | set_flags;
    next_flags = next_flags & enables; // [RULE_15]
    if (card_type_select) begin
      next_flags[1] = 1'b0; // [RULE_12]
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      detect_change_flag <= 1'b0;
      ready_change_flag <= 1'b0;
      battery_status_flag <= 1'b0;
    end else begin
      detect_change_flag <= next_flags[2];
      ready_change_flag <= next_flags[1];
      battery_status_flag <= next_flags[0];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------------
  // The request follows the flags, so it holds until the last flag is cleared,
  // whether that is by write-back or by the clearing read.
  wire status_request = detect_change_flag || ready_change_flag ||
                        battery_status_flag; // [RULE_17] [RULE_19]
  // A memory card's busy line is no request, so it is routed only in I/O mode.
  wire card_request = card_type_select && !busy_n;
  wire [15:0] irq_lines = steer(irq_steering_field, card_request) |
                          steer(status_irq_steering, status_request);

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      socket_out_en <= 1'b0;
      data_buffer_enable_n <= 1'b1;
      address_buffer_enable_n <= 1'b1;
      card_power_on <= 1'b0;
      card_supply_select <= 8'h00;
      card_reset_out <= 1'b1;
      card_is_io <= 1'b0;
      socket_irq <= 1'b0;
    end else begin
      socket_out_en <= drive_enable; // [RULE_01]
      data_buffer_enable_n <= !(drive_enable && card_access); // [RULE_01]
      address_buffer_enable_n <= !(drive_enable && card_access); // [RULE_01]
      card_power_on <= socket_power_enable && card_present; // [RULE_04]
      card_supply_select <= (socket_power_enable && card_present) ?
                            voltage_select_reg : 8'h00; // [RULE_03]
      card_reset_out <= !card_reset_control; // [RULE_08]
      card_is_io <= card_type_select; // [RULE_09]
      socket_irq <= |(irq_lines & ~irq_line_mask); // [RULE_20]
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Reserved bits are never stored, so they fall out of the mux as constants.
  reg [7:0] read_mux;

  always @* begin
    read_mux = 8'h00;
    case (reg_index)
      `CCS_IDX_POWER_DRIVE: begin
        read_mux[`CCS_PD_OE_BIT] = drive_enable;
        read_mux[`CCS_PD_ONE_BIT] = 1'b1; // [RULE_06]
        read_mux[`CCS_PD_PWR_BIT] = socket_power_enable;
      end
      `CCS_IDX_INT_GENERAL: begin
        read_mux[`CCS_IG_RI_BIT] = ring_indicate_select;
        read_mux[`CCS_IG_RST_BIT] = card_reset_control;
        read_mux[`CCS_IG_TYPE_BIT] = card_type_select;
        read_mux[3:0] = irq_steering_field;
      end
      `CCS_IDX_STATUS_CHG: begin
        read_mux[`CCS_SC_DETECT_BIT] = detect_change_flag;
        read_mux[`CCS_SC_READY_BIT] = ready_change_flag;
        read_mux[`CCS_SC_BATTERY_BIT] = battery_status_flag;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `CCS_RDATA_RESET;
    end else if (reg_read) begin
      reg_rdata <= read_mux;
    end
  end

endmodule

`default_nettype wire

// file: ccs_defs.vh
// Constants for the card socket control and status-change register bank.
// Assumes inclusion by its bare name from the design file that uses it.
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define CCS_IDX_POWER_DRIVE 8'h02
`define CCS_IDX_INT_GENERAL 8'h03
`define CCS_IDX_STATUS_CHG 8'h04

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCS_PD_OE_BIT 7
`define CCS_PD_ONE_BIT 5
`define CCS_PD_PWR_BIT 4
`define CCS_IG_RI_BIT 7
`define CCS_IG_RST_BIT 6
`define CCS_IG_TYPE_BIT 5
`define CCS_SC_DETECT_BIT 3
`define CCS_SC_READY_BIT 2
`define CCS_SC_BATTERY_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCS_IRQSEL_RESET 4'h3
`define CCS_RDATA_RESET 8'h00

`endif

// file: ccs_card.sv
// Behavioural removable card standing in the card socket.
// Assumes the bench moves present, busy and stat just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ccs_card (
  input wire logic present,
  input wire logic busy,
  input wire logic stat,
  output logic card_detect_a_n,
  output logic card_detect_b_n,
  output logic card_busy_n,
  output logic card_status_change_n
);
  // The socket lines have pull-ups, so an empty socket reads high on every line.
  assign card_detect_a_n = !present;
  assign card_detect_b_n = !present;
  assign card_busy_n = present ? !busy : 1'b1;
  assign card_status_change_n = present ? !stat : 1'b1;
endmodule
`default_nettype wire

// file: ccs_ctrl_properties.sv
// Concurrent checks on the ports of the card socket register bank.
// Assumes the bench spaces writes to one index at least two cycles apart.
`timescale 1ns/1ps
`default_nettype none
module ccs_ctrl_checker (
  input wire clock,
  input wire rst_n,
  input wire [7:0] reg_index,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire [7:0] voltage_select_reg,
  input wire detect_change_enable,
  input wire [15:0] irq_line_mask,
  input wire socket_out_en,
  input wire data_buffer_enable_n,
  input wire address_buffer_enable_n,
  input wire card_power_on,
  input wire [7:0] card_supply_select,
  input wire card_reset_out,
  input wire card_is_io,
  input wire socket_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire wr3 = reg_write && reg_index == 8'h03;
  drive_off_a: assert property (!socket_out_en |-> data_buffer_enable_n && address_buffer_enable_n)
    else $error("buffer enable active while socket outputs are off");
  supply_off_a: assert property (!card_power_on |-> card_supply_select == 8'h00)
    else $error("supply selected while card power is off");
  supply_sel_a: assert property (card_power_on |-> card_supply_select == $past(voltage_select_reg))
    else $error("supply differs from voltage select while powered");
  reset_ctl_a: assert property (wr3 |-> ##2 card_reset_out == !$past(reg_wdata[6], 2))
    else $error("card reset output does not follow its control bit");
  type_ctl_a: assert property (wr3 |-> ##2 card_is_io == $past(reg_wdata[5], 2))
    else $error("card type output does not follow its control bit");
  pd_reserved_a: assert property (reg_read && reg_index == 8'h02 |=>
    reg_rdata[6:5] == 2'b01 && reg_rdata[3:0] == 4'h0)
    else $error("reserved bits of power register read wrong");
  detect_gate_a: assert property ((!detect_change_enable) [*3] ##0
    (reg_read && reg_index == 8'h04) |=> !reg_rdata[3])
    else $error("detect flag set while its enable is low");
  irq_mask_a: assert property ((irq_line_mask == 16'hffff) [*2] |-> !socket_irq)
    else $error("socket interrupt raised with every line masked");
endmodule
bind ccs_ctrl ccs_ctrl_checker chk (.clock(clock), .rst_n(rst_n), .reg_index(reg_index),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .voltage_select_reg(voltage_select_reg), .detect_change_enable(detect_change_enable),
  .irq_line_mask(irq_line_mask), .socket_out_en(socket_out_en),
  .data_buffer_enable_n(data_buffer_enable_n), .address_buffer_enable_n(address_buffer_enable_n),
  .card_power_on(card_power_on), .card_supply_select(card_supply_select),
  .card_reset_out(card_reset_out), .card_is_io(card_is_io), .socket_irq(socket_irq));
`default_nettype wire

// file: test_card_socket_ctrl_status.sv
// Self-checking bench for the card socket register bank with a card model.
// Assumes ccs_ctrl and ccs_card are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_card_socket_ctrl_status;
  logic clock = 0, rst_n = 0, wen = 0, ren = 0, acc = 0, present = 0, busy = 0, stat = 0;
  logic det_en = 1, rdy_en = 1, bat_en = 1, wb = 0;
  logic [7:0] idx = 8'h00, wd = 8'h00, vsel = 8'h01;
  logic [3:0] steer = 4'h3;
  logic [15:0] mask = 16'hffff;
  wire [7:0] rdata, supply;
  wire cda_n, cdb_n, busy_n, stat_n, out_en, den_n, aen_n, pwr, rst_out, is_io, irq;
  int fails = 0, compares = 0;
  always #10 clock = ~clock;
  ccs_ctrl dut (.clock(clock), .rst_n(rst_n), .reg_index(idx), .reg_wdata(wd), .reg_write(wen),
    .reg_read(ren), .reg_rdata(rdata), .voltage_select_reg(vsel), .detect_change_enable(det_en),
    .ready_change_enable(rdy_en), .battery_change_enable(bat_en), .status_irq_steering(steer),
    .explicit_writeback_mode(wb), .irq_line_mask(mask), .card_access(acc),
    .card_detect_a_n(cda_n), .card_detect_b_n(cdb_n), .card_busy_n(busy_n),
    .card_status_change_n(stat_n), .socket_out_en(out_en), .data_buffer_enable_n(den_n),
    .address_buffer_enable_n(aen_n), .card_power_on(pwr), .card_supply_select(supply),
    .card_reset_out(rst_out), .card_is_io(is_io), .socket_irq(irq));
  ccs_card card (.present(present), .busy(busy), .stat(stat), .card_detect_a_n(cda_n),
    .card_detect_b_n(cdb_n), .card_busy_n(busy_n), .card_status_change_n(stat_n));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clock);
    idx <= i;
    wd <= d;
    wen <= 1;
    @(posedge clock);
    wen <= 0;
  endtask
  task rd(input logic [7:0] i, input logic [7:0] e);
    @(posedge clock);
    idx <= i;
    ren <= 1;
    @(posedge clock);
    ren <= 0;
    #1;
    chk("reg_rdata", e, rdata);
  endtask
  task conclude;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task t_reset;
    cyc(1);
    chk("card_reset_out", 1, rst_out);
    chk("buffer_enables", 8'h03, {den_n, aen_n});
    rd(8'h02, 8'h20);
    rd(8'h03, 8'h03);
    rd(8'h04, 8'h00);
    rd(8'h07, 8'h00);
  endtask
  task t_ctrl;
    wr(8'h03, 8'h40);
    cyc(2);
    chk("card_reset_out", 0, rst_out);
    wr(8'h03, 8'h70);
    rd(8'h03, 8'h60);
    chk("card_is_io", 1, is_io);
    wr(8'h03, 8'h40);
  endtask
  task t_power;
    wr(8'h02, 8'h10);
    acc <= 1;
    cyc(2);
    chk("buffer_enables", 8'h03, {den_n, aen_n});
    wr(8'h02, 8'h90);
    cyc(2);
    chk("socket_out_en", 1, out_en);
    chk("buffer_enables", 8'h00, {den_n, aen_n});
    chk("card_power_on", 0, pwr);
    @(posedge clock);
    present <= 1;
    acc <= 0;
    cyc(6);
    chk("card_power_on", 1, pwr);
    chk("card_supply_select", 8'h01, supply);
    rd(8'h02, 8'hb0);
    rd(8'h04, 8'h08);
    rd(8'h04, 8'h00);
  endtask
  task t_steer;
    logic [15:0] valid;
    valid = 16'hdeb8;
    @(posedge clock);
    present <= 0;
    cyc(6);
    chk("card_supply_select", 8'h00, supply);
    chk("card_power_on", 0, pwr);
    for (int c = 0; c < 16; c++) begin
      @(posedge clock);
      steer <= c[3:0];
      mask <= ~(16'h0001 << c);
      cyc(3);
      chk("socket_irq", valid[c], irq);
    end
    @(posedge clock);
    steer <= 4'h3;
    mask <= 16'h0008;
    cyc(3);
    chk("socket_irq", 0, irq);
    @(posedge clock);
    mask <= 16'hfff7;
    cyc(3);
    chk("socket_irq", 1, irq);
    rd(8'h04, 8'h08);
    cyc(2);
    chk("socket_irq", 0, irq);
  endtask
  task t_wb;
    @(posedge clock);
    wb <= 1;
    present <= 1;
    cyc(6);
    rd(8'h04, 8'h08);
    rd(8'h04, 8'h08);
    chk("socket_irq", 1, irq);
    wr(8'h04, 8'h08);
    rd(8'h04, 8'h00);
    chk("socket_irq", 0, irq);
    @(posedge clock);
    wb <= 0;
  endtask
  task t_ready;
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      busy <= 1;
      cyc(6);
      if (k == 1) chk("socket_irq", 1, irq);
      @(posedge clock);
      busy <= 0;
      cyc(6);
      rd(8'h04, k == 0 ? 8'h04 : 8'h00);
      wr(8'h03, 8'h63);
    end
    wr(8'h03, 8'h40);
  endtask
  task t_batt;
    @(posedge clock);
    stat <= 1;
    cyc(6);
    rd(8'h04, 8'h01);
    wr(8'h03, 8'h60);
    @(posedge clock);
    stat <= 0;
    cyc(6);
    @(posedge clock);
    stat <= 1;
    cyc(6);
    rd(8'h04, 8'h01);
    wr(8'h03, 8'h40);
    @(posedge clock);
    stat <= 0;
    cyc(6);
    @(posedge clock);
    stat <= 1;
    cyc(6);
    chk("socket_irq", 1, irq);
    @(posedge clock);
    bat_en <= 0;
    det_en <= 0;
    cyc(4);
    rd(8'h04, 8'h00);
    chk("socket_irq", 0, irq);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1;
    t_reset;
    t_ctrl;
    t_power;
    t_steer;
    t_wb;
    t_ready;
    t_batt;
    conclude;
  end
  // A hung handshake must not stall the run, so a cycle budget closes it out.
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    conclude;
  end
endmodule
`default_nettype wire
